// *** logic/bms_pkg.sv ***
// Constants, register map and state codes of the bypass mode and source select block.
// Assumes a 125 MHz system clock and an APB master with 32-bit data.
package bms_pkg;
	localparam logic [7:0] OFS_POWER_UP   = 8'h00;
	localparam logic [7:0] OFS_SPEED_SRC  = 8'h04;
	localparam logic [7:0] OFS_RUN_SRC    = 8'h08;
	localparam logic [7:0] OFS_ANALOG_CFG = 8'h0c;
	localparam logic [7:0] OFS_CONTROL    = 8'h10;
	localparam logic [7:0] OFS_KEYPAD_REF = 8'h14;
	localparam logic [7:0] OFS_PRESET0    = 8'h18;
	localparam logic [7:0] OFS_PRESET3    = 8'h24;
	localparam logic [7:0] OFS_MIN_FREQ   = 8'h28;
	localparam logic [7:0] OFS_STATUS     = 8'h2c;

	localparam logic [15:0] RST_POWER_UP  = 16'h0000;
	localparam logic [15:0] RST_SPEED_SRC = 16'h0001;
	localparam logic [15:0] RST_RUN_SRC   = 16'h0001;

	localparam logic [15:0] MAX_POWER_UP  = 16'h0004;
	localparam logic [15:0] MAX_SPEED_SRC = 16'h0003;
	localparam logic [15:0] MIN_RUN_SRC   = 16'h0001;
	localparam logic [15:0] MAX_RUN_SRC   = 16'h0003;

	// Analog config fields
	localparam int AN_PRI_LSB = 0;
	localparam int AN_SEC_LSB = 8;
	// Control fields
	localparam int CTL_PRESET_EN  = 0;
	localparam int CTL_KEY_BYPASS = 1;
	localparam int CTL_RESTART    = 2;

	// Full scale 16'h7fff is 20 mA; 4 mA is one fifth of it
	localparam logic signed [19:0] LIVE_ZERO = 20'sh0199a;

	localparam int unsigned CLK_KHZ       = 125000;
	localparam int unsigned FLASH_HALF_MS = 500;
	localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;

	typedef enum logic [2:0] {
		ST_OFF         = 3'b000,
		ST_AUTO_DRIVE  = 3'b001,
		ST_HAND_DRIVE  = 3'b010,
		ST_AUTO_BYPASS = 3'b011,
		ST_HAND_BYPASS = 3'b100
	} bms_mode_type;
endpackage : bms_pkg

// *** logic/bms_select.sv ***
// Bypass mode state, speed reference routing and auto run source selection.
// Assumes keypad keys, run terminal and multi-speed inputs arrive asynchronously;
// analog, serial and option values come from logic on mclk.
`timescale 1ns/10ps
`default_nettype none
module bms_select #(
	parameter int unsigned FLASH_HALF_CYCLES = bms_pkg::FLASH_HALF_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        autoKey,
	input  wire logic        offKey,
	input  wire logic        handKey,
	input  wire logic        runTerminal,
	input  wire logic [1:0]  multiSpeed,
	input  wire logic [15:0] analogInPrimary,
	input  wire logic [15:0] analogInSecondary,
	input  wire logic [15:0] serialRef,
	input  wire logic        serialRun,
	input  wire logic [15:0] optionRef,
	input  wire logic        optionRun,
	output logic [15:0]      freqRef,
	output logic             driveRun,
	output logic             bypassRun,
	output logic             autoLed,
	output logic             handLed,
	output logic             offLed
);
	function automatic logic [15:0] scaleAnalog(input logic [15:0] raw, input logic [1:0] lvl);
		logic signed [19:0] t;
		t = ($signed({{4{raw[15]}}, raw}) - bms_pkg::LIVE_ZERO) * 20'sd5;
		t = t >>> 2;
		case (lvl)
			2'h1: scaleAnalog = raw;
			2'h2: scaleAnalog = t[19] ? 16'h0000 : t[15:0];
			default: scaleAnalog = raw[15] ? 16'h0000 : raw;
		endcase
	endfunction : scaleAnalog

	// Pin synchronisers
	logic [5:0] pinStage1_q;
	logic [5:0] pinStage2_q;
	logic [5:0] pinStage3_q;
	logic [5:0] pinF_q;
	logic [5:0] pinFd_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinStage1_q <= 6'h00;
			pinStage2_q <= 6'h00;
			pinStage3_q <= 6'h00;
			pinF_q      <= 6'h00;
			pinFd_q     <= 6'h00;
		end else begin
			pinStage1_q <= {multiSpeed, runTerminal, handKey, offKey, autoKey};
			pinStage2_q <= pinStage1_q;
			pinStage3_q <= pinStage2_q;
			pinF_q      <= (pinStage2_q & pinStage3_q) | (pinF_q & (pinStage2_q | pinStage3_q));
			pinFd_q     <= pinF_q;
		end
	end
	logic       autoEdge;
	logic       offEdge;
	logic       handEdge;
	logic       runDigital;
	logic [1:0] msel;
	assign autoEdge   = pinF_q[0] & ~pinFd_q[0];
	assign offEdge    = pinF_q[1] & ~pinFd_q[1];
	assign handEdge   = pinF_q[2] & ~pinFd_q[2];
	assign runDigital = pinF_q[3];
	assign msel       = pinF_q[5:4];

	// APB slave, one wait-free access phase
	logic [15:0] powerUp_q;
	logic [15:0] speedSrc_q;
	logic [15:0] runSrc_q;
	logic [1:0]  lvlPri_q;
	logic [1:0]  lvlSec_q;
	logic        presetEn_q;
	logic        keyBypass_q;
	logic [15:0] keypadRef_q;
	logic [15:0] minFreq_q;
	logic [15:0] preset_q [4];
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        setup;
	logic        wrEn;
	logic [31:0] rdData;
	logic        rdErr;
	logic        lowRef;
	bms_pkg::bms_mode_type mode_q;
	logic        driveRun_q;
	logic        bypassRun_q;
	logic [15:0] freqRef_q;

	assign setup = psel & ~penable & ~pready_q;
	assign wrEn  = psel & penable & pready_q & pwrite & ~pslverr_q;

	always_comb begin
		rdData = 32'h00000000;
		rdErr  = 1'b0;
		case (paddr)
			bms_pkg::OFS_POWER_UP:   rdData = {16'h0000, powerUp_q};
			bms_pkg::OFS_SPEED_SRC:  rdData = {16'h0000, speedSrc_q};
			bms_pkg::OFS_RUN_SRC:    rdData = {16'h0000, runSrc_q};
			bms_pkg::OFS_ANALOG_CFG: rdData = {22'h000000, lvlSec_q, 6'h00, lvlPri_q};
			bms_pkg::OFS_CONTROL:    rdData = {30'h00000000, keyBypass_q, presetEn_q};
			bms_pkg::OFS_KEYPAD_REF: rdData = {16'h0000, keypadRef_q};
			bms_pkg::OFS_MIN_FREQ:   rdData = {16'h0000, minFreq_q};
			bms_pkg::OFS_STATUS:
				rdData = {freqRef_q, 10'h000, lowRef, bypassRun_q, driveRun_q, mode_q};
			default: begin
				if (paddr >= bms_pkg::OFS_PRESET0 && paddr <= bms_pkg::OFS_PRESET3
						&& paddr[1:0] == 2'h0) begin
					rdData = {16'h0000, preset_q[2'(paddr[7:2] - bms_pkg::OFS_PRESET0[7:2])]};
				end else begin
					rdErr = 1'b1;
				end
			end
		endcase
	end

	// Refused writes answer with an error
	// range check on writes
	logic wrBad;
	always_comb begin
		wrBad = 1'b0;
		case (paddr)
			bms_pkg::OFS_POWER_UP:  wrBad = pwdata[15:0] > bms_pkg::MAX_POWER_UP;
			bms_pkg::OFS_SPEED_SRC: wrBad = pwdata[15:0] > bms_pkg::MAX_SPEED_SRC;
			bms_pkg::OFS_RUN_SRC:
				wrBad = pwdata[15:0] < bms_pkg::MIN_RUN_SRC || pwdata[15:0] > bms_pkg::MAX_RUN_SRC;
			bms_pkg::OFS_STATUS:    wrBad = 1'b1;
			default:                wrBad = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & (rdErr | (pwrite & wrBad));
			prdata_q  <= (setup & ~pwrite) ? rdData : 32'h00000000;
		end
	end

	logic restartReq;
	assign restartReq = wrEn && paddr == bms_pkg::OFS_CONTROL && pwdata[bms_pkg::CTL_RESTART];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			powerUp_q   <= bms_pkg::RST_POWER_UP;
			speedSrc_q  <= bms_pkg::RST_SPEED_SRC;
			runSrc_q    <= bms_pkg::RST_RUN_SRC;
			lvlPri_q    <= 2'h0;
			lvlSec_q    <= 2'h0;
			presetEn_q  <= 1'b0;
			keyBypass_q <= 1'b0;
			keypadRef_q <= 16'h0000;
			minFreq_q   <= 16'h0000;
			for (int i = 0; i < 4; i++) preset_q[i] <= 16'h0000;
		end else if (wrEn) begin
			case (paddr)
				bms_pkg::OFS_POWER_UP:   powerUp_q <= pwdata[15:0];
				bms_pkg::OFS_SPEED_SRC:  speedSrc_q <= pwdata[15:0];
				bms_pkg::OFS_RUN_SRC:    runSrc_q <= pwdata[15:0];
				bms_pkg::OFS_ANALOG_CFG: begin
					lvlPri_q <= pwdata[bms_pkg::AN_PRI_LSB +: 2];
					lvlSec_q <= pwdata[bms_pkg::AN_SEC_LSB +: 2];
				end
				bms_pkg::OFS_CONTROL: begin
					presetEn_q  <= pwdata[bms_pkg::CTL_PRESET_EN];
					keyBypass_q <= pwdata[bms_pkg::CTL_KEY_BYPASS];
				end
				bms_pkg::OFS_KEYPAD_REF: keypadRef_q <= pwdata[15:0];
				bms_pkg::OFS_MIN_FREQ:   minFreq_q <= pwdata[15:0];
				default: preset_q[2'(paddr[7:2] - bms_pkg::OFS_PRESET0[7:2])] <= pwdata[15:0];
			endcase
		end
	end

	// Power-up mode is taken once after reset, or again on a restart request
	logic applyPending_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			applyPending_q <= 1'b1;
		end else begin
			applyPending_q <= restartReq;
		end
	end

	// Off key wins over everything, including the power-up start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= bms_pkg::ST_OFF;
		end else if (offEdge) begin
			mode_q <= bms_pkg::ST_OFF;
		end else if (handEdge) begin
			mode_q <= keyBypass_q ? bms_pkg::ST_HAND_BYPASS : bms_pkg::ST_HAND_DRIVE;
		end else if (autoEdge) begin
			mode_q <= keyBypass_q ? bms_pkg::ST_AUTO_BYPASS : bms_pkg::ST_AUTO_DRIVE;
		end else if (applyPending_q) begin
			case (powerUp_q[2:0])
				3'h1: mode_q <= bms_pkg::ST_AUTO_DRIVE;
				3'h2: mode_q <= bms_pkg::ST_HAND_DRIVE;
				3'h3: mode_q <= bms_pkg::ST_AUTO_BYPASS;
				3'h4: mode_q <= bms_pkg::ST_HAND_BYPASS;
				default: mode_q <= bms_pkg::ST_OFF;
			endcase
		end
	end

	logic autoRun;
	always_comb begin
		case (runSrc_q[1:0])
			2'h2: autoRun = serialRun;
			2'h3: autoRun = optionRun;
			default: autoRun = runDigital;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			driveRun_q  <= 1'b0;
			bypassRun_q <= 1'b0;
		end else begin
			driveRun_q  <= (mode_q == bms_pkg::ST_AUTO_DRIVE && autoRun)
				|| mode_q == bms_pkg::ST_HAND_DRIVE;
			bypassRun_q <= (mode_q == bms_pkg::ST_AUTO_BYPASS && autoRun)
				|| mode_q == bms_pkg::ST_HAND_BYPASS;
		end
	end

	logic [15:0] refSel;
	always_comb begin
		case (speedSrc_q[1:0])
			2'h0: refSel = presetEn_q ? preset_q[msel] : keypadRef_q;
			2'h2: refSel = serialRef;
			2'h3: refSel = optionRef;
			default: begin
				refSel = msel[0] ? scaleAnalog(analogInSecondary, lvlSec_q)
					: scaleAnalog(analogInPrimary, lvlPri_q);
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			freqRef_q <= 16'h0000;
		end else begin
			freqRef_q <= refSel;
		end
	end

	// Lamps: a signed-negative reference counts as below minimum
	assign lowRef = freqRef_q[15] || freqRef_q == 16'h0000 || freqRef_q < minFreq_q;
	logic [31:0] flashCnt_q;
	logic        flash_q;
	logic        autoLed_q;
	logic        handLed_q;
	logic        offLed_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flashCnt_q <= 32'h00000000;
			flash_q    <= 1'b0;
		end else if (flashCnt_q >= FLASH_HALF_CYCLES - 1) begin
			flashCnt_q <= 32'h00000000;
			flash_q    <= ~flash_q;
		end else begin
			flashCnt_q <= flashCnt_q + 32'h00000001;
		end
	end

	// lamp pattern on a starved run
	logic runAny;
	assign runAny = driveRun_q | bypassRun_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			autoLed_q <= 1'b0;
			handLed_q <= 1'b0;
			offLed_q  <= 1'b1;
		end else begin
			autoLed_q <= mode_q == bms_pkg::ST_AUTO_DRIVE || mode_q == bms_pkg::ST_AUTO_BYPASS;
			handLed_q <= mode_q == bms_pkg::ST_HAND_DRIVE || mode_q == bms_pkg::ST_HAND_BYPASS;
			offLed_q  <= (runAny && lowRef) ? flash_q : mode_q == bms_pkg::ST_OFF;
		end
	end

	assign pready    = pready_q;
	assign prdata    = prdata_q;
	assign pslverr   = pslverr_q;
	assign freqRef   = freqRef_q;
	assign driveRun  = driveRun_q;
	assign bypassRun = bypassRun_q;
	assign autoLed   = autoLed_q;
	assign handLed   = handLed_q;
	assign offLed    = offLed_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_apb_answer: assert property (setup |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");
	a_power_bad_kept: assert property (
		wrEn && paddr == bms_pkg::OFS_POWER_UP |=> powerUp_q <= bms_pkg::MAX_POWER_UP)
		else $error("power-up code out of range stored");
	a_run_zero_kept: assert property (
		psel && penable && pready && pwrite && paddr == bms_pkg::OFS_RUN_SRC
		&& pwdata[15:0] == 16'h0000 |=> runSrc_q == $past(runSrc_q))
		else $error("run source zero accepted");
	a_off_stops: assert property (offEdge |=> mode_q == bms_pkg::ST_OFF ##1 !runAny)
		else $error("off command did not stop");
	a_start_auto: assert property (
		applyPending_q && powerUp_q == 16'h0001 && !offEdge && !handEdge && !autoEdge
		|=> mode_q == bms_pkg::ST_AUTO_DRIVE)
		else $error("auto drive start not applied");
	a_start_hbyp: assert property (
		mode_q == bms_pkg::ST_HAND_BYPASS |=> bypassRun_q && !driveRun_q)
		else $error("hand bypass not running bypass");
	a_serial_ref: assert property (
		speedSrc_q == 16'h0002 |=> freqRef_q == $past(serialRef))
		else $error("serial reference not routed");
	a_option_run: assert property (
		runSrc_q == 16'h0003 && mode_q == bms_pkg::ST_AUTO_DRIVE |=> driveRun_q == $past(optionRun))
		else $error("option run not routed");
	a_starved_lamp: assert property (
		runAny && lowRef |=> offLed_q == $past(flash_q))
		else $error("off lamp not flashing on starved run");

	c_start_hand: cover property (applyPending_q ##1 mode_q == bms_pkg::ST_HAND_DRIVE);
	c_analog_sec: cover property (speedSrc_q == 16'h0001 && msel[0] && lvlSec_q == 2'h2);
	c_bad_write: cover property (pslverr && pwrite);
	c_starved: cover property (runAny && lowRef);
endmodule : bms_select
`default_nettype wire

// *** verification/bms_far_side.sv ***
// Far side model: building automation controller on serial link and option slot.
// Assumes the bench sets the wanted reference and run bits; values move on mclk.
`timescale 1ns/10ps
`default_nettype none
module bms_far_side (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [15:0] refIn,
	input  wire logic [1:0]  runIn,
	output logic [15:0]      serialRef,
	output logic             serialRun,
	output logic [15:0]      optionRef,
	output logic             optionRun
);
	// reference supply
	// Option copy offset so the two sources can be told apart
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serialRef <= 16'h0000;
			optionRef <= 16'h0000;
		end else begin
			serialRef <= refIn;
			optionRef <= (refIn == 16'h0000) ? 16'h0000 : refIn + 16'h0100;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serialRun <= 1'b0;
			optionRun <= 1'b0;
		end else begin
			serialRun <= runIn[0];
			optionRun <= runIn[1];
		end
	end
endmodule : bms_far_side
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the mode and source select block.
// Assumes APB answers after one access cycle and short lamp flash for simulation.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, e;
	logic [2:0]  keys = 3'b000;
	logic        runTerminal = 1'b0;
	logic [1:0]  multiSpeed = 2'b00, farRun = 2'b00;
	logic [15:0] pri = 16'h0, sec = 16'h0, farVal = 16'h0, freqRef, sRef, oRef;
	logic        sRun, oRun, driveRun, bypassRun, autoLed, handLed, offLed;
	int          fails = 0, checks = 0, hi, lo;

	always #4 mclk = ~mclk;

	bms_select #(.FLASH_HALF_CYCLES(4)) dut (
		.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.autoKey(keys[0]), .offKey(keys[1]), .handKey(keys[2]), .runTerminal(runTerminal),
		.multiSpeed(multiSpeed), .analogInPrimary(pri), .analogInSecondary(sec),
		.serialRef(sRef), .serialRun(sRun), .optionRef(oRef), .optionRun(oRun),
		.freqRef(freqRef), .driveRun(driveRun), .bypassRun(bypassRun),
		.autoLed(autoLed), .handLed(handLed), .offLed(offLed));

	bms_far_side far (
		.mclk(mclk), .rst_n(rst_n), .refIn(farVal), .runIn(farRun),
		.serialRef(sRef), .serialRun(sRun), .optionRef(oRef), .optionRun(oRun));

	task automatic tally_and_finish();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt

	// Request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(1'b1, a, d);
		chkb(e, err);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rreg

	task automatic press(input int k);
		keys[k] <= 1'b1;
		wt(8);
		keys[k] <= 1'b0;
		wt(8);
	endtask : press

	task automatic aref(input logic [31:0] cfg, input logic [15:0] p, input logic [15:0] s,
		input logic [1:0] ms, input logic [15:0] exp);
		wreg(bms_pkg::OFS_ANALOG_CFG, cfg, 1'b0);
		pri <= p;
		sec <= s;
		multiSpeed <= ms;
		wt(10);
		chk({16'h0, freqRef}, {16'h0, exp});
	endtask : aref

	initial begin
		wt(20);
		chkb(offLed, 1'b1);
		rst_n <= 1'b1;
		wt(4);
		chkb(driveRun | bypassRun, 1'b0);
		rreg(bms_pkg::OFS_POWER_UP, 32'h0);
		rreg(bms_pkg::OFS_SPEED_SRC, 32'h1);
		rreg(bms_pkg::OFS_RUN_SRC, 32'h1);
		wreg(bms_pkg::OFS_POWER_UP, 32'h5, 1'b1);
		wreg(bms_pkg::OFS_SPEED_SRC, 32'h4, 1'b1);
		wreg(bms_pkg::OFS_RUN_SRC, 32'h0, 1'b1);
		wreg(8'h30, 32'h1, 1'b1);
		rreg(bms_pkg::OFS_POWER_UP, 32'h0);
		rreg(bms_pkg::OFS_SPEED_SRC, 32'h1);
		rreg(bms_pkg::OFS_RUN_SRC, 32'h1);
		runTerminal <= 1'b1;
		for (int c = 1; c <= 4; c++) begin
			wreg(bms_pkg::OFS_POWER_UP, 32'(c), 1'b0);
			wreg(bms_pkg::OFS_CONTROL, 32'h4, 1'b0);
			wt(20);
			apb(1'b0, bms_pkg::OFS_STATUS, 32'h0);
			chk({29'h0, rd[2:0]}, 32'(c));
			chkb(driveRun, c <= 2);
			chkb(bypassRun, c >= 3);
			chkb(autoLed, c[0]);
			chkb(handLed, !c[0]);
			press(1);
			chkb(driveRun | bypassRun, 1'b0);
		end
		wreg(bms_pkg::OFS_POWER_UP, 32'h0, 1'b0);
		wreg(bms_pkg::OFS_CONTROL, 32'h4, 1'b0);
		wt(20);
		chkb(driveRun | bypassRun, 1'b0);
		press(0);
		chkb(driveRun, 1'b1);
		runTerminal <= 1'b0;
		wt(10);
		chkb(driveRun, 1'b0);
		runTerminal <= 1'b1;
		aref(32'h0101, 16'h1000, 16'h2000, 2'b00, 16'h1000);
		aref(32'h0101, 16'h1000, 16'h2000, 2'b01, 16'h2000);
		aref(32'h0001, 16'hf000, 16'h0000, 2'b00, 16'hf000);
		aref(32'h0000, 16'hf000, 16'h0000, 2'b00, 16'h0000);
		aref(32'h0002, bms_pkg::LIVE_ZERO[15:0] + 16'h0400, 16'h0, 2'b00, 16'h0500);
		aref(32'h0003, 16'hf000, 16'h0000, 2'b00, 16'h0000);
		aref(32'h0300, 16'h0000, 16'h0800, 2'b01, 16'h0800);
		aref(32'h0200, 16'h0, bms_pkg::LIVE_ZERO[15:0] + 16'h0400, 2'b01, 16'h0500);
		wreg(bms_pkg::OFS_SPEED_SRC, 32'h0, 1'b0);
		wreg(bms_pkg::OFS_KEYPAD_REF, 32'h0123, 1'b0);
		wreg(bms_pkg::OFS_CONTROL, 32'h0, 1'b0);
		wt(10);
		chk({16'h0, freqRef}, 32'h0123);
		wreg(bms_pkg::OFS_CONTROL, 32'h1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wreg(bms_pkg::OFS_PRESET0 + 8'(4 * i), 32'h0a00 + 32'(i), 1'b0);
			multiSpeed <= 2'(i);
			wt(10);
			chk({16'h0, freqRef}, 32'h0a00 + 32'(i));
		end
		farVal <= 16'h0456;
		wreg(bms_pkg::OFS_SPEED_SRC, 32'h2, 1'b0);
		wt(4);
		chk({16'h0, freqRef}, 32'h0456);
		wreg(bms_pkg::OFS_SPEED_SRC, 32'h3, 1'b0);
		wt(4);
		chk({16'h0, freqRef}, 32'h0556);
		farVal <= 16'h0000;
		hi = 0;
		lo = 0;
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			if (offLed === 1'b1)
				hi++;
			if (offLed === 1'b0)
				lo++;
		end
		chkb(autoLed, 1'b1);
		chkb(hi > 4 && lo > 4, 1'b1);
		// Option copy of 16'h0010 arrives as 16'h0110
		farVal <= 16'h0010;
		wreg(bms_pkg::OFS_MIN_FREQ, 32'h0200, 1'b0);
		wt(4);
		rreg(bms_pkg::OFS_STATUS, 32'h01100029);
		wreg(bms_pkg::OFS_MIN_FREQ, 32'h0100, 1'b0);
		wt(4);
		rreg(bms_pkg::OFS_STATUS, 32'h01100009);
		chkb(offLed, 1'b0);
		for (int r = 2; r <= 3; r++) begin
			wreg(bms_pkg::OFS_RUN_SRC, 32'(r), 1'b0);
			farRun <= 2'(r - 1);
			wt(10);
			chkb(driveRun, 1'b1);
			farRun <= 2'(4 - r);
			wt(10);
			chkb(driveRun, 1'b0);
		end
		// Keypad commands steered to the bypass path
		wreg(bms_pkg::OFS_CONTROL, 32'h2, 1'b0);
		press(2);
		chkb(bypassRun, 1'b1);
		chkb(driveRun, 1'b0);
		chkb(handLed, 1'b1);
		chkb(offLed, 1'b0);
		press(0);
		chkb(autoLed, 1'b1);
		chkb(bypassRun, 1'b0);
		farRun <= 2'b10;
		wt(4);
		chkb(bypassRun, 1'b1);
		press(1);
		chkb(bypassRun | driveRun, 1'b0);
		chkb(offLed, 1'b1);
		tally_and_finish();
	end

	// Whole sequence needs a few hundred cycles
	initial begin
		wt(20000);
		fails++;
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
